// File: logic/acs_regs.vh
// Operation
// - Restart pin rising edge aborts conversion, restarts filter, begins fresh conversion.
// - Restart pin low forces data_ready_n high through the following conversion.
// - After settling time data_ready_n falls; first result is already settled.
// - Input select value 23h routes input 2 positive, input 3 negative.
// - Resume command in low-power idle wakes device, which then converts continuously.
// - Wakeup allows 64 modulator clocks of four master periods each.
// - One-shot data_ready_n falls after settling time plus 256 master periods.
// - After restart, mux change or wakeup, convert continuously at data rate.
// - Input step settles in 5, 3, 2, 1 ready periods by rate.
// - Each result is a 24-bit two's-complement word.
// - Full scale codes 7fffffh and 800000h, saturating beyond full scale.
// - Zero gives 000000h, one LSB 000001h, minus one LSB ffffffh.
// - Restart settling is 0.21 ms at 30 kSPS, scaling with master clock.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ======================================================================
// Data format
`define ACS_CODE_W          24
`define ACS_POS_FS          24'h7fffff
`define ACS_NEG_FS          24'h800000

// ======================================================================
// Input select fields and reset value
`define ACS_SEL_POS_LSB     4
`define ACS_SEL_NEG_LSB     0
`define ACS_SEL_RST         8'h01

// ======================================================================
// Timing, in master clock periods unless noted
`define ACS_CLKIN_KHZ       7680
`define ACS_MOD_DIV         4
`define ACS_WAKE_MODCLK     64
`define ACS_ONESHOT_EXTRA   256
`define ACS_PERIOD_BASE     256
// Settling time per rate in units of 10 us
`define ACS_SETTLE_10US_R0  21
`define ACS_SETTLE_10US_R1  25
`define ACS_SETTLE_10US_R2  31
`define ACS_SETTLE_10US_R3  44
// Step settling in ready periods per rate
`define ACS_STEP_R0         5
`define ACS_STEP_R1         3
`define ACS_STEP_R2         2
`define ACS_STEP_R3         1

`endif

// File: logic/acs_sat.v
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_sat #(
	parameter IN_W = 26
) (
	input  wire signed [IN_W-1:0]        value_i,
	output reg  [`ACS_CODE_W-1:0]        code_o
);

	// ======================================================================
	// Saturate wide filter value to the output code
	localparam signed [IN_W-1:0] POS_LIM = $signed({{(IN_W-`ACS_CODE_W){1'b0}}, `ACS_POS_FS});
	localparam signed [IN_W-1:0] NEG_LIM = $signed({{(IN_W-`ACS_CODE_W){1'b1}}, `ACS_NEG_FS});

	always @*
	begin
		if (value_i > POS_LIM)
			code_o = `ACS_POS_FS;
		else if (value_i < NEG_LIM)
			code_o = `ACS_NEG_FS;
		else
			code_o = value_i[`ACS_CODE_W-1:0];
	end

endmodule // acs_sat

// File: logic/acs_seq.v
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_seq #(
	parameter IN_W = 26
) (
	input  wire                     core_clk_i,
	input  wire                     sys_rst_i,
	input  wire                     conversion_restart_pin_i,
	input  wire                     master_clk_i,
	input  wire [1:0]               rate_sel_i,
	input  wire                     filter_restart_cmd_i,
	input  wire                     resume_conversion_cmd_i,
	input  wire                     low_power_idle_cmd_i,
	input  wire                     read_data_cmd_i,
	input  wire                     write_register_cmd_i,
	input  wire [7:0]               reg_wdata_i,
	input  wire signed [IN_W-1:0]   filter_data_i,
	output reg                      data_ready_n_o,
	output reg  [`ACS_CODE_W-1:0]   result_o,
	output reg  [7:0]               input_select_reg_o,
	output reg  [3:0]               pos_input_o,
	output reg  [3:0]               neg_input_o,
	output reg                      idle_o,
	output reg                      settled_o
);

	// ======================================================================
	// Constants
	localparam [2:0] ST_IDLE   = 3'd0;
	localparam [2:0] ST_WAKE   = 3'd1;
	localparam [2:0] ST_SETTLE = 3'd2;
	localparam [2:0] ST_RUN    = 3'd3;
	localparam [2:0] ST_HOLD   = 3'd4;

	localparam integer WAKE_T  = `ACS_WAKE_MODCLK * `ACS_MOD_DIV;
	localparam integer EXTRA_T = `ACS_ONESHOT_EXTRA;
	// Least times, so rounded up to whole master periods
	localparam integer SETTLE_T0 = (`ACS_SETTLE_10US_R0 * `ACS_CLKIN_KHZ + 99) / 100;
	localparam integer SETTLE_T1 = (`ACS_SETTLE_10US_R1 * `ACS_CLKIN_KHZ + 99) / 100;
	localparam integer SETTLE_T2 = (`ACS_SETTLE_10US_R2 * `ACS_CLKIN_KHZ + 99) / 100;
	localparam integer SETTLE_T3 = (`ACS_SETTLE_10US_R3 * `ACS_CLKIN_KHZ + 99) / 100;
	localparam integer PERIOD_T0 = `ACS_PERIOD_BASE * 1;
	localparam integer PERIOD_T1 = `ACS_PERIOD_BASE * 2;
	localparam integer PERIOD_T2 = `ACS_PERIOD_BASE * 4;
	localparam integer PERIOD_T3 = `ACS_PERIOD_BASE * 8;
	localparam integer STEP_N0   = `ACS_STEP_R0;
	localparam integer STEP_N1   = `ACS_STEP_R1;
	localparam integer STEP_N2   = `ACS_STEP_R2;
	localparam integer STEP_N3   = `ACS_STEP_R3;

	// ======================================================================
	// Pin synchronisers and master clock edge tick
	reg  [1:0]               pin_sync;
	reg                      pin_prev;
	reg  [1:0]               mclk_sync;
	reg                      mclk_prev;
	wire                     pin_s;
	wire                     pin_rise;
	wire                     tick;

	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pin_sync  <= 2'b11;
			pin_prev  <= 1'b1;
			mclk_sync <= 2'b00;
			mclk_prev <= 1'b0;
		end
		else
		begin
			pin_sync  <= {pin_sync[0], conversion_restart_pin_i};
			pin_prev  <= pin_sync[1];
			mclk_sync <= {mclk_sync[0], master_clk_i};
			mclk_prev <= mclk_sync[1];
		end
	end

	assign pin_s    = pin_sync[1];
	assign pin_rise = pin_s & ~pin_prev;
	assign tick     = mclk_sync[1] & ~mclk_prev;

	// ======================================================================
	// Rate dependent figures
	reg  [12:0]              settle_t;
	reg  [12:0]              period_t;
	reg  [2:0]               step_n;

	always @*
	begin
		case (rate_sel_i)
			2'd0:
			begin
				settle_t = SETTLE_T0[12:0];
				period_t = PERIOD_T0[12:0];
				step_n   = STEP_N0[2:0];
			end
			2'd1:
			begin
				settle_t = SETTLE_T1[12:0];
				period_t = PERIOD_T1[12:0];
				step_n   = STEP_N1[2:0];
			end
			2'd2:
			begin
				settle_t = SETTLE_T2[12:0];
				period_t = PERIOD_T2[12:0];
				step_n   = STEP_N2[2:0];
			end
			default:
			begin
				settle_t = SETTLE_T3[12:0];
				period_t = PERIOD_T3[12:0];
				step_n   = STEP_N3[2:0];
			end
		endcase
	end

	// ======================================================================
	// Output formatting
	wire [`ACS_CODE_W-1:0]   sat_code;

	acs_sat #(
		.IN_W    (IN_W)
	) u_sat (
		.value_i (filter_data_i),
		.code_o  (sat_code)
	);

	// ======================================================================
	// Sequencer
	reg  [2:0]               state;
	reg  [12:0]              cnt;
	reg                      oneshot;
	reg  [2:0]               step_cnt;
	reg  [2:0]               next_step;
	reg  [12:0]              settle_end;
	reg                      done;
	wire                     pin_abort;
	wire                     restarting;

	assign pin_abort  = ~pin_s | pin_rise;
	assign restarting = pin_abort | filter_restart_cmd_i | low_power_idle_cmd_i
	                  | (resume_conversion_cmd_i & ((state == ST_IDLE) | (state == ST_HOLD)));

	always @*
	begin
		settle_end = settle_t + (oneshot ? EXTRA_T[12:0] : 13'd0) - 13'd1;
		next_step  = (step_cnt < step_n) ? step_cnt + 3'd1 : step_cnt;
		done       = 1'b0;
		if (tick)
		begin
			if ((state == ST_SETTLE) && (cnt == settle_end))
				done = 1'b1;
			else if ((state == ST_RUN) && (cnt == period_t - 13'd1))
				done = 1'b1;
		end
	end

	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state    <= ST_SETTLE;
			cnt      <= 13'd0;
			oneshot  <= 1'b0;
			step_cnt <= 3'd0;
		end
		else if (~pin_s)
		begin
			state <= ST_HOLD;
			cnt   <= 13'd0;
		end
		else if (pin_rise)
		begin
			state    <= ST_SETTLE;
			cnt      <= 13'd0;
			oneshot  <= 1'b0;
			step_cnt <= 3'd0;
		end
		else if (filter_restart_cmd_i)
		begin
			// Parked until the resume command
			state <= ST_HOLD;
			cnt   <= 13'd0;
		end
		else if (low_power_idle_cmd_i)
		begin
			state <= ST_IDLE;
			cnt   <= 13'd0;
		end
		else if (resume_conversion_cmd_i && (state == ST_IDLE))
		begin
			state    <= ST_WAKE;
			cnt      <= 13'd0;
			oneshot  <= 1'b1;
			step_cnt <= 3'd0;
		end
		else if (resume_conversion_cmd_i && (state == ST_HOLD))
		begin
			state    <= ST_SETTLE;
			cnt      <= 13'd0;
			oneshot  <= 1'b0;
			step_cnt <= 3'd0;
		end
		else
		begin
			// A mux change without restart is an input step; it must not eat a tick
			if (write_register_cmd_i)
				step_cnt <= 3'd0;
			else if (done)
				step_cnt <= (state == ST_SETTLE) ? step_n : next_step;
			if (tick)
			begin
				case (state)
					ST_WAKE:
					begin
						if (cnt == WAKE_T[12:0] - 13'd1)
						begin
							state <= ST_SETTLE;
							cnt   <= 13'd0;
						end
						else
							cnt <= cnt + 13'd1;
					end
					ST_SETTLE:
					begin
						if (done)
						begin
							state   <= ST_RUN;
							cnt     <= 13'd0;
							oneshot <= 1'b0;
						end
						else
							cnt <= cnt + 13'd1;
					end
					ST_RUN:
					begin
						if (done)
							cnt <= 13'd0;
						else
							cnt <= cnt + 13'd1;
					end
					ST_IDLE, ST_HOLD:
						cnt <= 13'd0;
					default:
						state <= ST_HOLD;
				endcase
			end
		end
	end

	// ======================================================================
	// Outputs; completion beats a read in the same cycle
	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			data_ready_n_o     <= 1'b1;
			result_o           <= {`ACS_CODE_W{1'b0}};
			input_select_reg_o <= `ACS_SEL_RST;
			pos_input_o        <= 4'h0;
			neg_input_o        <= 4'h1;
			idle_o             <= 1'b0;
			settled_o          <= 1'b0;
		end
		else
		begin
			idle_o <= (state == ST_IDLE);
			if (restarting)
			begin
				data_ready_n_o <= 1'b1;
				settled_o      <= 1'b0;
			end
			else if (done)
			begin
				data_ready_n_o <= 1'b0;
				result_o       <= sat_code;
				settled_o      <= (state == ST_SETTLE) | (next_step >= step_n);
			end
			else if (read_data_cmd_i)
				data_ready_n_o <= 1'b1;
			if (write_register_cmd_i & ~pin_abort & ~filter_restart_cmd_i
			    & ~low_power_idle_cmd_i & ~resume_conversion_cmd_i)
			begin
				input_select_reg_o <= reg_wdata_i;
				pos_input_o        <= reg_wdata_i[`ACS_SEL_POS_LSB+3:`ACS_SEL_POS_LSB];
				neg_input_o        <= reg_wdata_i[`ACS_SEL_NEG_LSB+3:`ACS_SEL_NEG_LSB];
				if (~restarting & ~done)
					settled_o <= 1'b0;
			end
		end
	end

endmodule // acs_seq

// File: verification/acs_seq_chk.sv
`timescale 1ns/10ps
`include "acs_regs.vh"
// ====================
// Sequencing checks
module acs_seq_chk (
	input wire                   core_clk_i,
	input wire                   sys_rst_i,
	input wire                   conversion_restart_pin_i,
	input wire                   master_clk_i,
	input wire                   filter_restart_cmd_i,
	input wire                   resume_conversion_cmd_i,
	input wire                   low_power_idle_cmd_i,
	input wire                   write_register_cmd_i,
	input wire [7:0]             reg_wdata_i,
	input wire                   data_ready_n_o,
	input wire [`ACS_CODE_W-1:0] result_o,
	input wire [7:0]             input_select_reg_o,
	input wire [3:0]             pos_input_o,
	input wire [3:0]             neg_input_o,
	input wire                   idle_o,
	input wire                   settled_o
);
	reg  [12:0] ticks;
	reg  [1:0]  mck;
	reg         rdy_q;
	reg         seen;
	wire        quiet = conversion_restart_pin_i && !filter_restart_cmd_i && !low_power_idle_cmd_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ====================
	// Master ticks since last completion; slower rates only lengthen it
	always @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mck   <= 2'h0;
			ticks <= 13'h0;
			rdy_q <= 1'b1;
			seen  <= 1'b0;
		end
		else
		begin
			mck   <= {mck[0], master_clk_i};
			rdy_q <= data_ready_n_o;
			seen  <= seen | (rdy_q & ~data_ready_n_o);
			if (rdy_q && !data_ready_n_o)
				ticks <= 13'h0;
			else if (mck == 2'h1 && !(&ticks))
				ticks <= ticks + 13'h1;
		end
	end
	// ====================
	// Properties
	pin_low_a: assert property (!conversion_restart_pin_i [*4] |-> data_ready_n_o)
		else $error("ready low while restart pin low");
	restart_cmd_a: assert property (filter_restart_cmd_i |=> data_ready_n_o)
		else $error("ready low after restart command");
	idle_cmd_a: assert property (low_power_idle_cmd_i && conversion_restart_pin_i && !filter_restart_cmd_i
		|=> data_ready_n_o ##[0:1] idle_o)
		else $error("idle not entered");
	idle_ready_a: assert property (idle_o |-> data_ready_n_o)
		else $error("ready low in idle");
	resume_wake_a: assert property (idle_o && resume_conversion_cmd_i && quiet |-> ##[1:3] !idle_o)
		else $error("resume did not wake");
	sel_write_a: assert property (write_register_cmd_i && quiet && !resume_conversion_cmd_i
		|=> input_select_reg_o == $past(reg_wdata_i))
		else $error("select write lost");
	sel_map_a: assert property ($stable(input_select_reg_o) [*2] |->
		pos_input_o == input_select_reg_o[7:4] && neg_input_o == input_select_reg_o[3:0])
		else $error("input routing mismatch");
	result_hold_a: assert property (!$stable(result_o) |-> !data_ready_n_o)
		else $error("result changed without completion");
	run_period_a: assert property ($fell(data_ready_n_o) && seen |-> ticks >= 13'hf8)
		else $error("completions too close");
	settled_a: assert property ($rose(settled_o) |-> !data_ready_n_o)
		else $error("settled outside completion");
endmodule // acs_seq_chk

// File: verification/acs_host.sv
`timescale 1ns/10ps
// ====================
// Host: free-running master clock, one read per completion
module acs_host (
	input  wire core_clk_i,
	input  wire data_ready_n_i,
	input  wire auto_read_i,
	input  wire slow_i,
	output reg  master_clk_o,
	output reg  read_data_cmd_o
);
	reg [4:0] wait_cnt = 5'h0;
	reg       done = 1'b0;
	// Odd offset keeps master edges clear of the core clock edges
	initial
	begin
		master_clk_o = 1'b0;
		#3;
		forever #40 master_clk_o = ~master_clk_o;
	end
	always @(negedge core_clk_i)
	begin
		if (data_ready_n_i)
		begin
			wait_cnt <= 5'h0;
			done <= 1'b0;
			read_data_cmd_o <= 1'b0;
		end
		else if (auto_read_i && !done && wait_cnt == (slow_i ? 5'h14 : 5'h2))
		begin
			read_data_cmd_o <= 1'b1;
			done <= 1'b1;
		end
		else
		begin
			read_data_cmd_o <= 1'b0;
			if (auto_read_i && !done)
				wait_cnt <= wait_cnt + 5'h1;
		end
	end
endmodule // acs_host

// File: verification/acs_seq_tb.sv
`timescale 1ns/10ps
`include "acs_regs.vh"
`define CHK(w, e, g) begin num_checks++; if ((e) !== (g)) begin failures++; \
	$display("wrong value %s expected %h seen %h", w, e, g); end end
module acs_seq_tb;
	logic               core_clk = 1'b0;
	logic               rst = 1'b1;
	logic               pin = 1'b1;
	logic               f_rst = 1'b0;
	logic               resume = 1'b0;
	logic               sleep = 1'b0;
	logic               wr = 1'b0;
	logic               aread = 1'b1;
	logic               slow = 1'b0;
	logic [1:0]         rate = 2'h0;
	logic [7:0]         wdata = 8'h0;
	logic signed [25:0] fdata = 26'h0;
	wire                mclk, rd, data_ready_n, idle, settled;
	wire [23:0]         res;
	wire [7:0]          sel;
	wire [3:0]          pos, neg;
	int                 failures = 0;
	int                 num_checks = 0;
	int                 n;
	int                 cnt;
	acs_seq uut (.core_clk_i(core_clk), .sys_rst_i(rst), .conversion_restart_pin_i(pin),
		.master_clk_i(mclk), .rate_sel_i(rate), .filter_restart_cmd_i(f_rst),
		.resume_conversion_cmd_i(resume), .low_power_idle_cmd_i(sleep), .read_data_cmd_i(rd),
		.write_register_cmd_i(wr), .reg_wdata_i(wdata), .filter_data_i(fdata),
		.data_ready_n_o(data_ready_n), .result_o(res), .input_select_reg_o(sel), .pos_input_o(pos),
		.neg_input_o(neg), .idle_o(idle), .settled_o(settled));
	acs_host host (.core_clk_i(core_clk), .data_ready_n_i(data_ready_n), .auto_read_i(aread),
		.slow_i(slow), .master_clk_o(mclk), .read_data_cmd_o(rd));
	initial
		forever #5 core_clk = ~core_clk;
	// ====================
	// Helpers
	task automatic pulse(ref logic s);
		@(negedge core_clk);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask
	// Cycles from call to next ready fall, bounded
	task automatic wait_fall();
		bit hi;
		hi = 1'b0;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
			hi |= data_ready_n === 1'b1;
		end
		while (!(hi && data_ready_n === 1'b0) && n < 40000);
	endtask
	// One master tick is 8 core cycles here
	task automatic in_win(string w, int t);
		`CHK(w, 1'b1, n >= 8 * t - 24 && n <= 8 * t + 24)
	endtask
	// ====================
	// Scenarios
	task t_format();
		logic [25:0] vin [7] = '{26'h0, 26'h1, 26'h3ffffff, 26'h07fffff, 26'h1ffffff,
			26'h3800000, 26'h2000000};
		logic [23:0] vout [7] = '{24'h0, 24'h1, 24'hffffff, 24'h7fffff, 24'h7fffff,
			24'h800000, 24'h800000};
		wait_fall();
		in_win("reset settle", 1613);
		`CHK("settled", 1'b1, settled)
		for (int i = 0; i < 7; i++)
		begin
			fdata = vin[i];
			slow = i[0];
			wait_fall();
			in_win("run period", 256);
			`CHK("code", vout[i], res)
		end
		$display("test format done");
	endtask
	task t_pin();
		@(negedge core_clk);
		pin = 1'b0;
		repeat (40) @(negedge core_clk);
		`CHK("ready held", 1'b1, data_ready_n)
		fdata = 26'h0000123;
		pin = 1'b1;
		wait_fall();
		in_win("restart settle", 1613);
		`CHK("settled", 1'b1, settled)
		`CHK("restart code", 24'h000123, res)
		$display("test pin done");
	endtask
	task t_mux();
		wait_fall();
		// No read yet: select, restart and resume come first
		aread = 1'b0;
		wdata = 8'h23;
		pulse(wr);
		@(negedge core_clk);
		`CHK("select", 8'h23, sel)
		`CHK("positive input", 4'h2, pos)
		`CHK("negative input", 4'h3, neg)
		pulse(f_rst);
		@(negedge core_clk);
		`CHK("ready after restart", 1'b1, data_ready_n)
		pulse(resume);
		wait_fall();
		in_win("channel settle", 1613);
		wdata = 8'h45;
		pulse(wr);
		@(negedge core_clk);
		`CHK("unsettled", 1'b0, settled)
		aread = 1'b1;
		cnt = 0;
		while (settled !== 1'b1 && cnt < 8)
		begin
			wait_fall();
			@(negedge core_clk);
			cnt++;
		end
		`CHK("settling periods", `ACS_STEP_R0, cnt)
		$display("test mux done");
	endtask
	task t_oneshot();
		fdata = 26'h3fffff0;
		pulse(sleep);
		repeat (3) @(negedge core_clk);
		`CHK("idle", 1'b1, idle)
		`CHK("ready in idle", 1'b1, data_ready_n)
		rate = 2'h1;
		repeat (50) @(negedge core_clk);
		pulse(resume);
		wait_fall();
		// Wake 256, settle 1920 at the second rate, extra 256
		in_win("one-shot settle", 2432);
		`CHK("awake", 1'b0, idle)
		`CHK("one-shot settled", 1'b1, settled)
		`CHK("one-shot code", 24'hfffff0, res)
		wait_fall();
		in_win("second rate period", 512);
		$display("test one-shot done");
	endtask
	task results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		t_format();
		t_pin();
		t_mux();
		t_oneshot();
		results();
	end
	initial
	begin
		#1000000;
		failures++;
		results();
	end
endmodule // acs_seq_tb
bind acs_seq acs_seq_chk chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.conversion_restart_pin_i(conversion_restart_pin_i), .master_clk_i(master_clk_i),
	.filter_restart_cmd_i(filter_restart_cmd_i), .resume_conversion_cmd_i(resume_conversion_cmd_i),
	.low_power_idle_cmd_i(low_power_idle_cmd_i), .write_register_cmd_i(write_register_cmd_i),
	.reg_wdata_i(reg_wdata_i), .data_ready_n_o(data_ready_n_o), .result_o(result_o),
	.input_select_reg_o(input_select_reg_o), .pos_input_o(pos_input_o),
	.neg_input_o(neg_input_o), .idle_o(idle_o), .settled_o(settled_o));
